// ### hw/ddl_pkg.sv
// package: widths, codes and timing constants for the dual double-latch converter input
package ddl_pkg;
   localparam int unsigned CODE_WIDTH      = 14;
   localparam int unsigned FIFO_DEPTH      = 8;
   localparam int unsigned CLK_PERIOD_NS   = 20;
   // fastest update the source may ask for, in MSPS
   localparam int unsigned MAX_UPDATE_MSPS = 125;
   // least update period in ns, derived from the rate
   localparam int unsigned MIN_UPDATE_NS   = (1000 + MAX_UPDATE_MSPS - 1) / MAX_UPDATE_MSPS;
   // cycles of clk per strobe half period; two cycles keep both phases visible
   localparam int unsigned HALF_PERIOD_CYC = 2;
   localparam int unsigned MIN_HALF_CYC    = ((MIN_UPDATE_NS + 2 * CLK_PERIOD_NS - 1)
                                              / (2 * CLK_PERIOD_NS)) < 1 ? 1 :
                                             ((MIN_UPDATE_NS + 2 * CLK_PERIOD_NS - 1)
                                              / (2 * CLK_PERIOD_NS));
   localparam logic [13:0] CODE_FULL       = 14'h3fff;
   localparam logic [13:0] CODE_MID        = 14'h2000;
   localparam logic [13:0] CODE_ZERO       = 14'h0000;
   localparam logic [13:0] RESET_CODE      = 14'h0000;
   typedef logic [CODE_WIDTH-1:0] ddl_code_type;
   typedef enum logic {DDL_SEP_RES, DDL_ONE_RES} ddl_gain_type;
endpackage

// ### hw/ddl_link_if.sv
// interface joining the sample source to the dual converter input
`timescale 1ns/1ps
interface ddl_link_if;
   import ddl_pkg::*;
   ddl_code_type chanAData;
   ddl_code_type chanBData;
   logic         chanAInputStrobe;
   logic         chanBInputStrobe;
   logic         chanAUpdateClock;
   logic         chanBUpdateClock;
   logic         sleepRequest;
   logic         gainResistorSelect;
   modport device (input chanAData, input chanBData, input chanAInputStrobe,
                   input chanBInputStrobe, input chanAUpdateClock, input chanBUpdateClock,
                   input sleepRequest, input gainResistorSelect);
   modport source (output chanAData, output chanBData, output chanAInputStrobe,
                   output chanBInputStrobe, output chanAUpdateClock, output chanBUpdateClock,
                   output sleepRequest, output gainResistorSelect);
endinterface

// ### hw/ddl_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module ddl_fifo #(
   parameter int unsigned WIDTH = 28,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   wire              doWrite = inValid && inReady;
   wire              doRead  = outValid && outReady;
   // full at DEPTH words; the count is one bit wider than the pointers
   assign inReady  = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData  = store[rdPtr];
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else
      begin
         if (doWrite)
         begin
            store[wrPtr] <= inData;
            wrPtr        <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         end
         if (doRead)
            rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
      end
   end
endmodule // ddl_fifo

// ### hw/ddl_source.sv
// sample source end: buffers sample pairs and drives strobe and update clock together
`timescale 1ns/1ps
module ddl_source (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire ddl_pkg::ddl_code_type sampleA,
   input  wire ddl_pkg::ddl_code_type sampleB,
   input  wire logic                  sampleValid,
   output logic                       sampleReady,
   input  wire logic                  sleepIn,
   input  wire logic                  oneResistorIn,
   ddl_link_if.source                 link
);
   import ddl_pkg::*;
   typedef enum logic [1:0] {SRC_IDLE, SRC_HIGH, SRC_LOW} src_state_type;
   src_state_type state;
   logic [1:0]    halfCnt;
   ddl_code_type  holdA;
   ddl_code_type  holdB;
   logic          strobe;
   logic          sleepReg;
   logic          gainReg;
   logic [27:0]   fifoData;
   logic          fifoValid;
   wire           halfDone = (halfCnt == 2'(HALF_PERIOD_CYC - 1));
   // pop exactly where the state machine loads a word, so none is skipped
   wire           takeWord = fifoValid && ((state == SRC_IDLE) ||
                                           (state == SRC_HIGH && halfDone));
   ddl_fifo #(.WIDTH(28), .DEPTH(FIFO_DEPTH)) buffer (
      .clk      (clk),
      .rst_n    (rst_n),
      .inData   ({sampleA, sampleB}),
      .inValid  (sampleValid),
      .inReady  (sampleReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (takeWord)
   );
   // one wire drives both strobe and update clock, so clock never lags strobe
   assign link.chanAInputStrobe   = strobe;
   assign link.chanAUpdateClock   = strobe;
   assign link.chanBInputStrobe   = strobe;
   assign link.chanBUpdateClock   = strobe;
   assign link.chanAData          = holdA;
   assign link.chanBData          = holdB;
   assign link.sleepRequest       = sleepReg;
   assign link.gainResistorSelect = gainReg;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state    <= SRC_IDLE;
         halfCnt  <= '0;
         holdA    <= RESET_CODE;
         holdB    <= RESET_CODE;
         strobe   <= 1'b0;
         sleepReg <= 1'b0;
         gainReg  <= 1'b0;
      end
      else
      begin
         sleepReg <= sleepIn;
         gainReg  <= oneResistorIn;
         // data changes while strobe is low, settling a full half period before the rise
         case (state)
            SRC_IDLE:
            begin
               if (fifoValid)
               begin
                  {holdA, holdB} <= fifoData;
                  state          <= SRC_LOW;
                  halfCnt        <= '0;
               end
            end
            SRC_LOW:
            begin
               halfCnt <= halfDone ? '0 : halfCnt + 1'b1;
               if (halfDone)
               begin
                  strobe <= 1'b1;  // equal halves, period 80 ns, below the rate cap
                  state  <= SRC_HIGH;
               end
            end
            SRC_HIGH:
            begin
               halfCnt <= halfDone ? '0 : halfCnt + 1'b1;
               if (halfDone)
               begin
                  strobe <= 1'b0;
                  state  <= fifoValid ? SRC_LOW : SRC_IDLE;
                  if (fifoValid)
                     {holdA, holdB} <= fifoData;
               end
            end
            default: state <= SRC_IDLE;
         endcase
      end
   end
endmodule // ddl_source

// ### hw/ddl_converter.sv
// converter end: two independent double-latch channels with output code model
`timescale 1ns/1ps
module ddl_converter (
   input  wire logic             clk,
   input  wire logic             rst_n,
   ddl_link_if.device            link,
   output ddl_pkg::ddl_code_type chanAOutCode,
   output ddl_pkg::ddl_code_type chanAOutCompl,
   output ddl_pkg::ddl_code_type chanBOutCode,
   output ddl_pkg::ddl_code_type chanBOutCompl,
   output logic                  chanAUpdated,
   output logic                  chanBUpdated,
   output logic                  sleeping,
   output ddl_pkg::ddl_gain_type gainMode
);
   import ddl_pkg::*;

   // upper code bits steer equal segments and the rest stay binary weighted,
   // which keeps the glitch of a midscale step small
   localparam int unsigned SEG_BITS  = 5;
   localparam int unsigned LSB_BITS  = CODE_WIDTH - SEG_BITS;
   localparam int unsigned SEG_COUNT = (1 << SEG_BITS) - 1;

   // unary decode of the segment field: switch i is on when the field exceeds i
   function automatic logic [SEG_COUNT-1:0] seg_decode(input logic [SEG_BITS-1:0] field);
      logic [SEG_COUNT-1:0] therm;
      therm = '0;
      for (int i = 0; i < SEG_COUNT; i++)
      begin
         therm[i] = (i < int'(field));
      end
      return therm;
   endfunction

   // weight of a set of segment switches, in units of one segment
   function automatic logic [SEG_BITS-1:0] seg_count(input logic [SEG_COUNT-1:0] switches);
      logic [SEG_BITS-1:0] total;
      total = '0;
      for (int i = 0; i < SEG_COUNT; i++)
      begin
         total = total + SEG_BITS'(switches[i]);
      end
      return total;
   endfunction

   // per channel arrays so the two channels share no state
   ddl_code_type dataIn  [2];
   logic         strobeIn[2];
   logic         clockIn [2];
   ddl_code_type outCode [2];
   ddl_code_type outCompl[2];
   logic         updated [2];
   logic         sleepNow;
   ddl_gain_type gainNow;

   // channel A on pair one, channel B on pair two
   assign dataIn[0]   = link.chanAData;
   assign dataIn[1]   = link.chanBData;
   assign strobeIn[0] = link.chanAInputStrobe;
   assign strobeIn[1] = link.chanBInputStrobe;
   assign clockIn[0]  = link.chanAUpdateClock;
   assign clockIn[1]  = link.chanBUpdateClock;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_chan
         logic                 strobeQ;
         logic                 clockQ;
         ddl_code_type         inputLatch;
         ddl_code_type         stageLatch;
         ddl_code_type         convLatch;
         logic                 pulse;
         logic [SEG_COUNT-1:0] segOn;
         logic [LSB_BITS-1:0]  lsbOn;
         // pins are sampled on clk, so edges are found by comparing with last sample
         wire strobeRise = strobeIn[ch] && !strobeQ;
         wire strobeFall = !strobeIn[ch] && strobeQ;
         wire clockRise  = clockIn[ch] && !clockQ;

         // last pin levels reset to the idle low, so no false edge follows reset
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               strobeQ <= 1'b0;
               clockQ  <= 1'b0;
            end
            else
            begin
               strobeQ <= strobeIn[ch];
               clockQ  <= clockIn[ch];
            end
         end

         // first stage takes the word on the strobe rise
         always_ff @(posedge clk)
         begin
            if (!rst_n)
               inputLatch <= RESET_CODE;
            else if (strobeRise)
               inputLatch <= dataIn[ch];
         end

         // a capture is not offered to the converter latch until the fall
         always_ff @(posedge clk)
         begin
            if (!rst_n)
               stageLatch <= RESET_CODE;
            else if (strobeFall)
               stageLatch <= inputLatch;
         end

         // tied strobe and clock: clock rise loads the word passed by the previous fall
         always_ff @(posedge clk)
         begin
            if (!rst_n)
               convLatch <= RESET_CODE;
            else if (clockRise)
               convLatch <= stageLatch;
         end

         // no edge, no change in any stage
         always_ff @(posedge clk)
         begin
            if (!rst_n)
               pulse <= 1'b0;
            else
               pulse <= clockRise;  // decoder refresh marks each update
         end

         // switches follow the converter latch only, so they move once per update
         assign segOn = seg_decode(convLatch[CODE_WIDTH-1:LSB_BITS]);
         assign lsbOn = convLatch[LSB_BITS-1:0];
         // true output sums the switches on, complement those off
         assign outCode[ch]  = {seg_count(segOn), lsbOn};
         assign outCompl[ch] = {seg_count(~segOn), ~lsbOn};
         assign updated[ch]  = pulse;
      end
   endgenerate

   // channel A outputs; code, complement and pulse move together
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         chanAOutCode  <= CODE_ZERO;
         chanAOutCompl <= CODE_FULL;
         chanAUpdated  <= 1'b0;
      end
      else
      begin
         chanAOutCode  <= outCode[0];
         chanAOutCompl <= outCompl[0];
         chanAUpdated  <= updated[0];
      end
   end

   // channel B outputs, kept apart from channel A
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         chanBOutCode  <= CODE_ZERO;
         chanBOutCompl <= CODE_FULL;
         chanBUpdated  <= 1'b0;
      end
      else
      begin
         chanBOutCode  <= outCode[1];
         chanBOutCompl <= outCompl[1];
         chanBUpdated  <= updated[1];
      end
   end

   // an open pin reads as awake, standing in for the pull-down
   assign sleepNow = (link.sleepRequest === 1'b1);
   assign gainNow  = link.gainResistorSelect ? DDL_ONE_RES : DDL_SEP_RES;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sleeping <= 1'b0;
         gainMode <= DDL_SEP_RES;
      end
      else
      begin
         sleeping <= sleepNow;
         gainMode <= gainNow;
      end
   end
endmodule // ddl_converter

// ### tb/ddl_link_properties.sv
// checker: wire-level properties of the link between source and converter ends
`timescale 1ns/1ps
module ddl_link_properties (
   input wire logic                 clk,
   input wire logic                 rst_n,
   input wire ddl_pkg::ddl_code_type chanAData,
   input wire ddl_pkg::ddl_code_type chanBData,
   input wire logic                 chanAInputStrobe,
   input wire logic                 chanBInputStrobe,
   input wire logic                 chanAUpdateClock,
   input wire logic                 chanBUpdateClock,
   input wire logic                 sleepRequest,
   input wire logic                 gainResistorSelect
);
   import ddl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // tied strobe and clock give zero clock-to-strobe delay
   a_clock_tie_a: assert property (chanAUpdateClock == chanAInputStrobe)
      else $error("channel a clock and strobe differ");
   a_clock_tie_b: assert property (chanBUpdateClock == chanBInputStrobe)
      else $error("channel b clock and strobe differ");
   a_high_phase_a: assert property ($rose(chanAInputStrobe) |=>
      chanAInputStrobe ##1 !chanAInputStrobe)
      else $error("channel a high phase not two cycles");
   a_high_phase_b: assert property ($rose(chanBInputStrobe) |=>
      chanBInputStrobe ##1 !chanBInputStrobe)
      else $error("channel b high phase not two cycles");
   a_low_phase_a: assert property ($fell(chanAInputStrobe) |=> !chanAInputStrobe)
      else $error("channel a low phase too short");
   a_low_phase_b: assert property ($fell(chanBInputStrobe) |=> !chanBInputStrobe)
      else $error("channel b low phase too short");
   // data may only move while the strobe is low, so capture never sees a change
   a_data_hold_a: assert property (chanAInputStrobe |-> $stable(chanAData))
      else $error("channel a data moved while strobe high");
   a_data_hold_b: assert property (chanBInputStrobe |-> $stable(chanBData))
      else $error("channel b data moved while strobe high");
   c_strobe_a: cover property ($rose(chanAInputStrobe));
   c_sleep: cover property ($rose(sleepRequest));
   c_gain: cover property ($rose(gainResistorSelect));
endmodule // ddl_link_properties

// ### tb/tb_top.sv
// testbench: both ends joined, a queue model checks every converter update
`timescale 1ns/1ps
module tb_top;
   import ddl_pkg::*;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   ddl_code_type sampleA = '0;
   ddl_code_type sampleB = '0;
   logic         sampleValid = 1'b0;
   logic         sampleReady;
   logic         sleepIn = 1'b0;
   logic         oneResistorIn = 1'b0;
   ddl_code_type chanAOutCode, chanAOutCompl, chanBOutCode, chanBOutCompl;
   logic         chanAUpdated, chanBUpdated, sleeping;
   logic         sawFull = 1'b0;
   ddl_gain_type gainMode;
   int           numErrors = 0;
   int           nChecks = 0;
   int           nUpd = 0;
   int           nPush = 0;
   ddl_code_type qA[$], qB[$];
   ddl_code_type prevA = RESET_CODE, prevB = RESET_CODE, holdA;
   ddl_code_type edgeA[3] = '{CODE_FULL, CODE_MID, CODE_ZERO};
   always #10 clk = ~clk;
   ddl_link_if ddl_link_if_inst ();
   ddl_source ddl_source_inst (.clk(clk), .rst_n(rst_n), .sampleA(sampleA), .sampleB(sampleB),
      .sampleValid(sampleValid), .sampleReady(sampleReady), .sleepIn(sleepIn),
      .oneResistorIn(oneResistorIn), .link(ddl_link_if_inst.source));
   ddl_converter ddl_converter_inst (.clk(clk), .rst_n(rst_n), .link(ddl_link_if_inst.device),
      .chanAOutCode(chanAOutCode), .chanAOutCompl(chanAOutCompl), .chanBOutCode(chanBOutCode),
      .chanBOutCompl(chanBOutCompl), .chanAUpdated(chanAUpdated), .chanBUpdated(chanBUpdated),
      .sleeping(sleeping), .gainMode(gainMode));
   ddl_link_properties ddl_link_properties_inst (.clk(clk), .rst_n(rst_n),
      .chanAData(ddl_link_if_inst.chanAData), .chanBData(ddl_link_if_inst.chanBData),
      .chanAInputStrobe(ddl_link_if_inst.chanAInputStrobe),
      .chanBInputStrobe(ddl_link_if_inst.chanBInputStrobe),
      .chanAUpdateClock(ddl_link_if_inst.chanAUpdateClock),
      .chanBUpdateClock(ddl_link_if_inst.chanBUpdateClock),
      .sleepRequest(ddl_link_if_inst.sleepRequest),
      .gainResistorSelect(ddl_link_if_inst.gainResistorSelect));
   task automatic chk(input logic ok, input string msg);
      nChecks++;
      if (ok !== 1'b1)
      begin
         numErrors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic reportAndStop();
      $display("checks %0d errors %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // holds valid and data until the edge that sees ready high
   task automatic push(input ddl_code_type a, input ddl_code_type b);
      sampleA     <= a;
      sampleB     <= b;
      sampleValid <= 1'b1;
      do
         @(posedge clk);
      while (sampleReady !== 1'b1);
      qA.push_back(a);
      qB.push_back(b);
      nPush++;
   endtask
   task automatic drain();
      for (int n = 0; n < 400 && nUpd != nPush; n++)
         @(posedge clk);
      repeat (4) @(posedge clk);
      chk(nUpd == nPush, "update count");
   endtask
   // output lags one update: each load shows the word captured at the previous rise
   always @(posedge clk)
   begin
      if (sampleValid === 1'b1 && sampleReady === 1'b0)
         sawFull <= 1'b1;
      if (rst_n === 1'b1 && chanAUpdated === 1'b1)
      begin
         chk(chanAOutCode === prevA && chanAOutCompl === CODE_FULL - prevA,
             "chan a code");
         chk(chanBUpdated === 1'b1 && chanBOutCode === prevB, "chan b code");
         chk(chanBOutCompl === CODE_FULL - prevB && qA.size() > 0, "chan b compl");
         if (qA.size() > 0)
         begin
            prevA = qA.pop_front();
            prevB = qB.pop_front();
         end
         nUpd++;
      end
   end
   initial
   begin
      ddl_code_type a;
      int           seed;
      seed = $urandom(32'h0d91);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // boundary codes, then random, 14 back to back so the fifo fills and refuses
      for (int i = 0; i < 14; i++)
      begin
         a = (i < 3) ? edgeA[i] : ddl_code_type'($urandom);
         push(a, (i < 3) ? edgeA[2 - i] : ddl_code_type'($urandom));
      end
      sampleValid <= 1'b0;
      drain();
      chk(sawFull === 1'b1, "fifo never refused");
      holdA = chanAOutCode;
      repeat (20) @(posedge clk);
      chk(chanAOutCode === holdA && chanAUpdated === 1'b0, "code not held");
      for (int k = 0; k < 4; k++)
      begin
         sleepIn       <= k[0];
         oneResistorIn <= k[1];
         repeat (5) @(posedge clk);
         chk(sleeping === k[0], "sleep level");
         chk(gainMode === (k[1] ? DDL_ONE_RES : DDL_SEP_RES), "gain mode");
      end
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk(chanAOutCode === RESET_CODE && chanBOutCompl === CODE_FULL, "reset values");
      prevA = RESET_CODE;
      prevB = RESET_CODE;
      nUpd  = 0;
      nPush = 0;
      rst_n <= 1'b1;
      @(posedge clk);
      // gaps of at least one edge so valid is never assigned twice in one step
      repeat (20)
      begin
         push(ddl_code_type'($urandom), ddl_code_type'($urandom));
         sampleValid <= 1'b0;
         repeat ($urandom_range(1, 6)) @(posedge clk);
      end
      drain();
      reportAndStop();
   end
   initial
   begin
      #(CLK_PERIOD_NS * 20000);
      numErrors++;
      $display("[ERR] %0t watchdog expired", $time);
      reportAndStop();
   end
endmodule // tb_top
